// file: icc_checker.sv
// Checker for the control word block, sees top ports only.
// Assumes one-cycle register strobes on ref_clk_i.
`timescale 1ns/1ps
module icc_checker
    import icc_pkg::*;
(
    // Clock, reset and register port
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [icc_pkg::ICC_AW-1:0] addr_i,
    input wire logic [icc_pkg::ICC_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [icc_pkg::ICC_DW-1:0] rdata_o,
    // Request and outputs
    input wire logic irq_valid_i,
    input wire logic multi_vector_o,
    input wire logic [9:0] vector_gap_o,
    input wire logic prox_start_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Alias writes aimed at the mode bit
    sequence s_set_multi_vector_select;
        wr_i && addr_i == ICC_SET_OFS && wdata_i[ICC_MULTI_VECTOR_SELECT_BIT];
    endsequence
    sequence s_clr_multi_vector_select;
        wr_i && addr_i == ICC_CLR_OFS && wdata_i[ICC_MULTI_VECTOR_SELECT_BIT];
    endsequence
    chk_gap_legal: assert property ($onehot0(vector_gap_o) && vector_gap_o[2:0] == 3'h0)
        else $error("gap not a legal size");
    chk_gap_single: assert property (!multi_vector_o |-> vector_gap_o == 10'h000)
        else $error("gap used in single mode");
    chk_set_alias: assert property (s_set_multi_vector_select |=> ##1 multi_vector_o)
        else $error("set alias missed");
    chk_clr_alias: assert property (s_clr_multi_vector_select |=> ##1 !multi_vector_o)
        else $error("clear alias missed");
    chk_multi_vector_select_hold: assert property (!wr_i |=> ##1 $stable(multi_vector_o))
        else $error("mode moved without write");
    chk_unimpl_zero: assert property ((rdata_o & ~ICC_CTRL_MASK) == 32'h0000_0000)
        else $error("unimplemented bit read high");
    chk_rd_quiet: assert property (rdata_o != 32'h0000_0000 |-> $past(rd_i))
        else $error("read data without read");
    chk_prox_cause: assert property (prox_start_o |-> $past(irq_valid_i))
        else $error("timer start without request");
endmodule // icc_checker
bind icc_top icc_checker chk_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .irq_valid_i, .multi_vector_o, .vector_gap_o,
    .prox_start_o);

// file: icc_cpu_model.sv
// CPU-side model: turns the vector gap into the offset of vector 3.
// Assumes block outputs are already registered.
`timescale 1ns/1ps
module icc_cpu_model (
    // Configuration from the block
    input wire logic multi_vector_i,
    input wire logic [9:0] vector_gap_i,
    // Offset of vector 3 from the base
    output logic [11:0] vec3_ofs_o
);
    // Single-vector mode takes every request at the base
    assign vec3_ofs_o = multi_vector_i ? 12'(vector_gap_i) * 12'h003 : 12'h000;
endmodule // icc_cpu_model

// file: icc_edge.sv
// Edge detector for one external interrupt input with selectable polarity.
// Assumes the input is already synchronous to ref_clk_i.
`timescale 1ns/1ps
module icc_edge (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Input and polarity
    input wire logic pin_i,
    input wire logic rising_i,
    // Detected edge
    output logic edge_o
);
    logic prev_reg;

    // Previous sample of the pin
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin_i;
        end
    end

    // Edge pulse, direction picked by polarity
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_o <= 1'b0;
        end else if (rising_i) begin
            edge_o <= pin_i & ~prev_reg; // RULE_08
        end else begin
            edge_o <= ~pin_i & prev_reg; // RULE_08
        end
    end
endmodule // icc_edge

// file: icc_pkg.sv
// Package for the interrupt control configuration block.
// Assumes a plain register port with 32-bit data and byte addresses.
package icc_pkg;
    localparam int ICC_AW = 8;
    localparam int ICC_DW = 32;
    // Control word base and atomic alias offsets
    localparam logic [7:0] ICC_CTRL_OFS = 8'h00;
    localparam logic [7:0] ICC_CLR_OFS = 8'h04;
    localparam logic [7:0] ICC_SET_OFS = 8'h08;
    localparam logic [7:0] ICC_INV_OFS = 8'h0C;
    // Field positions
    localparam int ICC_GAP_LSB = 16;
    localparam int ICC_GAP_W = 7;
    localparam int ICC_MULTI_VECTOR_SELECT_BIT = 12;
    localparam int ICC_THR_LSB = 8;
    localparam int ICC_THR_W = 3;
    localparam int ICC_EXT_N = 5;
    // Implemented bits of the control word
    localparam logic [31:0] ICC_CTRL_MASK = 32'h007F_171F;
    localparam logic [31:0] ICC_CTRL_RESET = 32'h0000_0000;
    // Smallest nonzero vector gap in bytes
    localparam logic [9:0] ICC_GAP_UNIT = 10'h008;
    localparam logic [2:0] ICC_THR_OFF = 3'h0;
    localparam logic [2:0] ICC_THR_ONE = 3'h1;

    // Register port request
    typedef struct packed {
        logic [ICC_AW-1:0] addr;
        logic [ICC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } icc_req_t;

    // Decoded configuration
    typedef struct packed {
        logic multi_vector_select;
        logic [9:0] vector_gap_bytes;
        logic [2:0] proximity_timer_threshold;
        logic [ICC_EXT_N-1:0] ext_irq_polarity;
    } icc_cfg_t;

    typedef enum logic [1:0] {
        ICC_OP_WRITE = 2'b00,
        ICC_OP_CLR = 2'b01,
        ICC_OP_SET = 2'b10,
        ICC_OP_INV = 2'b11
    } icc_op_t;
endpackage : icc_pkg

// file: icc_top.sv
// Interrupt control configuration: global control word, alias writes,
// decoded vector gap, proximity timer start and external edge detection.
// Assumes a single-cycle register master and synchronous pin inputs.
// Notes on behaviour
// RULE_01: The seven-bit gap field is one-hot, zero means 0 bytes, bit n means 8<<n bytes.
// RULE_02: Software only writes the eight legal gap encodings.
// RULE_03: The gap field is ignored while single-vector mode is selected.
// RULE_04: Bit 12 set selects multivector mode, clear selects single-vector mode.
// RULE_05: Threshold codes 2 to 7 let any group priority at or below the code start the timer.
// RULE_06: Threshold code 1 lets only group priority 1 start the timer.
// RULE_07: Threshold code 0 disables the proximity timer start.
// RULE_08: Polarity bits 4 and 3 choose rising edge when 1, falling when 0.
// RULE_09: Polarity bits 2 to 0 choose rising edge when 1, falling when 0.
// RULE_10: Unimplemented control word bits always read as zero.
// RULE_11: The control word also answers at base plus 4, 8 and 12 for clear, set, invert.
// RULE_12: Priority and subpriority style registers reset to all zeros.
// RULE_13: Alias writes clear, set or toggle only the implemented bits written as one.
`timescale 1ns/1ps
module icc_top
    import icc_pkg::*;
#(
    parameter int EXT_N = icc_pkg::ICC_EXT_N
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [icc_pkg::ICC_AW-1:0] addr_i,
    input wire logic [icc_pkg::ICC_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [icc_pkg::ICC_DW-1:0] rdata_o,
    // Interrupt request priority from the source arbitration
    input wire logic irq_valid_i,
    input wire logic [2:0] irq_group_prio_i,
    // External interrupt pins
    input wire logic [EXT_N-1:0] ext_irq_i,
    // Configuration to the CPU-facing vector logic
    output logic multi_vector_o,
    output logic [9:0] vector_gap_o,
    output logic [2:0] group_prio_o,
    // Proximity timer start and external edge events
    output logic prox_start_o,
    output logic [EXT_N-1:0] ext_edge_o
);
    import icc_pkg::*;

    icc_req_t req;
    icc_cfg_t cfg;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic hit;
    icc_op_t op;
    logic [EXT_N-1:0] edge_w;

    // Bundle the request
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Address decode shared by read and write paths
    function automatic logic ctrl_hit(input logic [ICC_AW-1:0] a);
        ctrl_hit = (a == ICC_CTRL_OFS) || (a == ICC_CLR_OFS) ||
                   (a == ICC_SET_OFS) || (a == ICC_INV_OFS); // RULE_11
    endfunction

    function automatic icc_op_t ctrl_op(input logic [ICC_AW-1:0] a);
        case (a)
            ICC_CLR_OFS: ctrl_op = ICC_OP_CLR;
            ICC_SET_OFS: ctrl_op = ICC_OP_SET;
            ICC_INV_OFS: ctrl_op = ICC_OP_INV;
            default: ctrl_op = ICC_OP_WRITE;
        endcase
    endfunction

    // One-hot gap field to byte spacing; reserved patterns give 0 bytes
    function automatic logic [9:0] gap_bytes(input logic [ICC_GAP_W-1:0] g);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 0; i < ICC_GAP_W; i++) begin
            if (g == (ICC_GAP_W'(1) << i)) begin
                r = ICC_GAP_UNIT << i; // RULE_01
            end
        end
        gap_bytes = r;
    endfunction

    assign hit = ctrl_hit(req.addr);
    assign op = ctrl_op(req.addr);

    // Next value of the control word, alias ops touch only masked bits
    always_comb begin
        ctrl_next = ctrl_reg;
        if (req.wr && hit) begin
            case (op)
                ICC_OP_CLR: ctrl_next = ctrl_reg & ~(req.wdata & ICC_CTRL_MASK); // RULE_13
                ICC_OP_SET: ctrl_next = ctrl_reg | (req.wdata & ICC_CTRL_MASK); // RULE_13
                ICC_OP_INV: ctrl_next = ctrl_reg ^ (req.wdata & ICC_CTRL_MASK); // RULE_13
                default: ctrl_next = req.wdata & ICC_CTRL_MASK;
            endcase
        end
    end

    // Control word storage
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= ICC_CTRL_RESET; // RULE_12
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (req.rd && hit) begin
            rdata_o <= ctrl_reg & ICC_CTRL_MASK; // RULE_10
        end else begin
            rdata_o <= '0;
        end
    end

    // Decode fields from the stored word
    assign cfg.multi_vector_select = ctrl_reg[ICC_MULTI_VECTOR_SELECT_BIT]; // RULE_04
    assign cfg.vector_gap_bytes =
        gap_bytes(ctrl_reg[ICC_GAP_LSB +: ICC_GAP_W]);
    assign cfg.proximity_timer_threshold = ctrl_reg[ICC_THR_LSB +: ICC_THR_W];
    assign cfg.ext_irq_polarity = ctrl_reg[ICC_EXT_N-1:0];

    // Registered configuration outputs
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            multi_vector_o <= 1'b0;
            vector_gap_o <= '0;
            group_prio_o <= '0;
        end else begin
            multi_vector_o <= cfg.multi_vector_select; // RULE_04
            // Gap means nothing in single-vector mode, so force it to zero
            vector_gap_o <= cfg.multi_vector_select ?
                cfg.vector_gap_bytes : 10'h000; // RULE_03
            group_prio_o <= irq_valid_i ? irq_group_prio_i : 3'h0;
        end
    end

    // Proximity timer start on qualifying group priority
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prox_start_o <= 1'b0;
        end else if (!irq_valid_i) begin
            prox_start_o <= 1'b0;
        end else begin
            case (cfg.proximity_timer_threshold)
                ICC_THR_OFF: prox_start_o <= 1'b0; // RULE_07
                ICC_THR_ONE: prox_start_o <= (irq_group_prio_i == ICC_THR_ONE); // RULE_06
                default: prox_start_o <=
                    (irq_group_prio_i <= cfg.proximity_timer_threshold); // RULE_05
            endcase
        end
    end

    // One edge detector per external input
    genvar gi;
    generate
        for (gi = 0; gi < EXT_N; gi++) begin : g_edge
            icc_edge u_edge (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .pin_i(ext_irq_i[gi]),
                .rising_i(cfg.ext_irq_polarity[gi]), // RULE_09
                .edge_o(edge_w[gi])
            );
        end
    endgenerate

    // Retime edges so the top output comes from a flip-flop here too
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_edge_o <= '0;
        end else begin
            ext_edge_o <= edge_w;
        end
    end
endmodule // icc_top

// file: tb_top.sv
// Testbench for the control word block and its CPU-side model.
// Assumes the checker is bound to the top module.
`timescale 1ns/1ps
module tb_top;
    import icc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} icc_row_t;
    logic ref_clk_i, rst_i, wr_i, rd_i, irq_valid_i, multi_vector_o, prox_start_o;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic [2:0] irq_group_prio_i, group_prio_o;
    logic [4:0] ext_irq_i, ext_edge_o, seen;
    logic [9:0] vector_gap_o;
    logic [11:0] vec3;
    int n_fail, n_compared;
    // Alias rows; gap field kept one-hot, unmapped write leaves word alone
    icc_row_t rows[7] = '{'{8'h00, 32'hFFC0_FFFF, 32'h0040_171F},
        '{8'h04, 32'h0000_1000, 32'h0040_071F}, '{8'h0C, 32'h0000_001F, 32'h0040_0700},
        '{8'h08, 32'hFF80_00E5, 32'h0040_0705}, '{8'h0C, 32'h0060_0000, 32'h0020_0705},
        '{8'h10, 32'hFFFF_FFFF, 32'h0020_0705}, '{8'h08, 32'h0000_1000, 32'h0020_1705}};
    icc_top dut_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .irq_valid_i, .irq_group_prio_i, .ext_irq_i, .multi_vector_o,
        .vector_gap_o, .group_prio_o, .prox_start_o, .ext_edge_o);
    icc_cpu_model cpu_u (.multi_vector_i(multi_vector_o), .vector_gap_i(vector_gap_o),
        .vec3_ofs_o(vec3));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] w);
        @(posedge ref_clk_i);
        addr_i <= a; wdata_i <= w; wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge ref_clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Pins change together; edges gathered over a short window
    task automatic pins(logic [4:0] v, logic [4:0] exp);
        @(posedge ref_clk_i);
        ext_irq_i <= v;
        seen = 5'h00;
        repeat (4) begin
            @(posedge ref_clk_i);
            #1 seen |= ext_edge_o;
        end
        check("edges", 32'(seen), 32'(exp));
    endtask
    initial begin
        #100000 n_fail++;
        test_done();
    end
    initial begin
        rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = '0;
        irq_valid_i = 1'b0; irq_group_prio_i = 3'h0; ext_irq_i = 5'h00;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(ICC_CTRL_OFS); check("reset word", d, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(ICC_CTRL_OFS); check("word", d, rows[i].r);
        end
        rd(8'h10); check("unmapped", d, 32'h0000_0000);
        // Every legal one-hot gap code, then the zero code
        for (int k = 0; k < 8; k++) begin
            wr(ICC_CTRL_OFS, {9'h000, 7'(k < 7 ? 1 << k : 0), 16'h1000});
            repeat (2) @(posedge ref_clk_i);
            #1 check("gap", 32'(vector_gap_o), k < 7 ? 32'h8 << k : 0);
            check("vec3", 32'(vec3), k < 7 ? 32'h18 << k : 0);
            check("mode", 32'(multi_vector_o), 32'h0000_0001);
        end
        wr(ICC_CTRL_OFS, 32'h0040_0000);
        repeat (2) @(posedge ref_clk_i);
        #1 check("gap single", 32'(vector_gap_o), 32'h0000_0000);
        check("mode single", 32'(multi_vector_o), 32'h0000_0000);
        check("vec3 single", 32'(vec3), 32'h0000_0000);
        // All thresholds against all priorities
        for (int t = 0; t < 8; t++) begin
            wr(ICC_CTRL_OFS, 32'(t) << 8);
            for (int p = 0; p < 8; p++) begin
                @(posedge ref_clk_i);
                irq_valid_i <= 1'b1; irq_group_prio_i <= 3'(p);
                @(posedge ref_clk_i);
                #1 check("prox", 32'(prox_start_o), 32'(t == 1 ? p == 1 : t != 0 && p <= t));
                check("prio", 32'(group_prio_o), 32'(p));
            end
        end
        irq_valid_i <= 1'b0;
        wr(ICC_CTRL_OFS, 32'h0000_0015);
        // No request presented: both request outputs must drop
        #1 check("prio idle", 32'(group_prio_o), 32'h0000_0000);
        check("prox idle", 32'(prox_start_o), 32'h0000_0000);
        pins(5'h1F, 5'h15);
        pins(5'h00, 5'h0A);
        // Reset in mid-run clears the word
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(ICC_CTRL_OFS); check("mid reset", d, 32'h0000_0000);
        test_done();
    end
endmodule // tb_top
